/* bench/host_model.sv */
// external host processor model driving the host port
`timescale 1ns/10ps

module host_model
  import host_port_pkg::*;
(
  input wire logic clk,
  output logic host_mem_wr,
  output logic host_mem_rd,
  output logic host_status_rd,
  output logic [15:0] host_addr,
  output logic [15:0] host_data_in
);
  // ==========================================================
  // idle levels; the data bus never idles at a helpful value
  initial begin
    host_mem_wr = 1'b0;
    host_mem_rd = 1'b0;
    host_status_rd = 1'b0;
    host_addr = 16'h0000;
    host_data_in = 16'hffff;
  end

  // one strobe cycle per access: 0 write, 1 memory read, 2 status read
  task automatic access(input logic [1:0] kind, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    // host software keeps both swap bits equal
    if (kind == 2'd0 && a == ADDR_ROUTING) v[RT_SWAP_LO] = v[RT_SWAP_HI];
    @(negedge clk);
    host_addr = a;
    host_data_in = v;
    host_mem_wr = (kind == 2'd0);
    host_mem_rd = (kind == 2'd1);
    host_status_rd = (kind == 2'd2);
    @(negedge clk);
    host_mem_wr = 1'b0;
    host_mem_rd = 1'b0;
    host_status_rd = 1'b0;
    host_data_in = ~v; // released bus shows the inverse, not the last value
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench for host port routing, doorbells and mailbox
`timescale 1ns/10ps

module tb;
  import host_port_pkg::*;
  logic clk, rst, cpu_wr, cpu_rd, host_mem_wr, host_mem_rd, host_status_rd;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, host_addr, host_data_in, host_data_out;
  logic host_data_oe, host_mem_cycle, host_interrupt_pin, vbus_lvl, id_lvl;
  logic en_rx, en_tx, irq_rx, irq_tx, rd_d;
  logic [9:0] ev;
  wire [9:0] cirq;
  logic [15:0] hq[$], cq[$];
  logic mq[$];
  int errors, cmp_count, cyc;
  logic [15:0] d;
  // event order: vbus, id, frame 1, 2, bus reset 1, 2, resume 1, 2, done 1, 2
  int rbit[10] = '{15, 14, 11, 13, 1, 9, 6, 7, 2, 3};
  int sbit[10] = '{-1, -1, 10, 12, 1, 9, 6, 7, 2, 3};
  int cbit[10] = '{0, 0, 10, 12, 0, 0, 0, 0, 0, 0};

  host_port_irq_routing_mailbox u_dut (.clk, .rst, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .host_mem_wr, .host_mem_rd, .host_status_rd, .host_addr, .host_data_in,
    .host_data_out, .host_data_oe, .host_mem_cycle, .host_interrupt_pin,
    .vbus_above_threshold(vbus_lvl), .otg_id_pin(id_lvl), .vbus_event(ev[0]),
    .id_event(ev[1]), .engine1_frame_event(ev[2]), .engine2_frame_event(ev[3]),
    .engine1_bus_reset_event(ev[4]), .engine2_bus_reset_event(ev[5]),
    .engine1_resume_event(ev[6]), .engine2_resume_event(ev[7]),
    .engine1_done_event(ev[8]), .engine2_done_event(ev[9]), .cpu_vbus_irq(cirq[0]),
    .cpu_id_irq(cirq[1]), .cpu_frame1_irq(cirq[2]), .cpu_frame2_irq(cirq[3]),
    .cpu_bus_reset_1_irq(cirq[4]), .cpu_bus_reset_2_irq(cirq[5]), .cpu_resume_1_irq(cirq[6]),
    .cpu_resume_2_irq(cirq[7]), .cpu_done_1_irq(cirq[8]), .cpu_done_2_irq(cirq[9]),
    .mbx_rx_full_irq_en(en_rx), .mbx_tx_empty_irq_en(en_tx),
    .cpu_mbx_rx_full_irq(irq_rx), .cpu_mbx_tx_empty_irq(irq_tx));

  host_model u_host (.clk, .host_mem_wr, .host_mem_rd, .host_status_rd, .host_addr,
    .host_data_in);

  // ==========================================================
  // clock, compare and closing
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    check(16'(hq.size() + mq.size() + cq.size()), 16'h0000);
    $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      end_of_test();
    end
  end

  // monitor: answers stand one cycle, so each is taken at that edge
  always @(posedge clk) begin
    if (host_data_oe === 1'b1) begin
      check(host_data_out, hq.pop_front());
      check(host_mem_cycle, mq.pop_front());
    end
    if (rd_d) check(cpu_rdata, cq.pop_front());
    rd_d <= cpu_rd;
  end

  // ==========================================================
  // cpu bus strobes, one cycle each, launched at the falling edge
  task automatic cpu_op(input logic w, input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = w;
    cpu_rd = !w;
    @(negedge clk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
  endtask

  task automatic hstat(input logic [15:0] exp);
    hq.push_back(exp);
    mq.push_back(1'b0);
    u_host.access(2'd2, 16'h0000, 16'h0000);
  endtask

  task automatic hread(input logic [15:0] a, input logic [15:0] exp);
    hq.push_back(exp);
    mq.push_back(1'b1);
    u_host.access(2'd1, a, 16'h0000);
  endtask

  // host writes routing, host and cpu both read it back
  task automatic set_routing(input logic [15:0] r);
    u_host.access(2'd0, ADDR_ROUTING, r);
    hread(ADDR_ROUTING, r & ROUTING_WRITABLE);
    cq.push_back(r & ROUTING_WRITABLE);
    cpu_op(1'b0, ADDR_ROUTING, 16'h0000);
  endtask

  // one event at a time against a routing value
  task automatic ev_pass(input logic [15:0] r);
    logic [15:0] rt, st;
    rt = r & ROUTING_WRITABLE;
    set_routing(r);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      ev = 10'h001 << i;
      repeat (2) @(negedge clk);
      check(host_interrupt_pin, rt[rbit[i]]);
      check(cirq[i], (i == 2 || i == 3) ? rt[cbit[i]] : !rt[rbit[i]]);
      st = 16'h0000;
      if (sbit[i] >= 0) st[sbit[i]] = rt[rbit[i]];
      hstat(st);
      ev = 10'h000; // bench alone drops a doubly routed frame event
    end
  endtask

  initial begin
    {cpu_wr, cpu_rd, vbus_lvl, id_lvl, en_rx, en_tx} = '0;
    cpu_addr = 16'h0000;
    cpu_wdata = 16'h0000;
    ev = 10'h000;
    rst = 1'b1;
    void'($urandom(7));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    // reset values; cpu writes to routing and cpu reads of doorbells refused
    cq.push_back(ROUTING_RESET);
    cpu_op(1'b0, ADDR_ROUTING, 16'h0000);
    cpu_op(1'b1, ADDR_ROUTING, 16'hffff);
    cq.push_back(ROUTING_RESET);
    cpu_op(1'b0, ADDR_ROUTING, 16'h0000);
    cq.push_back(READ_NONE);
    cpu_op(1'b0, ADDR_DOORBELL1, 16'h0000);
    hstat(16'h0000);
    $display("test reset done");
    // routing: all to host with reserved bits set, both frame ways, random
    ev_pass(16'heafe);
    ev_pass(16'h3c00);
    ev_pass(16'($urandom) & 16'hfefe);
    $display("test routing done");
    // pin levels appear after the settling wait
    @(negedge clk);
    vbus_lvl = 1'b1;
    repeat (10) @(negedge clk);
    hstat(16'h8000);
    vbus_lvl = 1'b0;
    id_lvl = 1'b1;
    repeat (4) @(negedge clk);
    hstat(16'h4000);
    id_lvl = 1'b0;
    repeat (4) @(negedge clk);
    $display("test pins done");
    // doorbells back to back, cleared by status and by memory reads
    cpu_op(1'b1, ADDR_DOORBELL1, 16'($urandom));
    cpu_op(1'b1, ADDR_DOORBELL2, 16'($urandom));
    repeat (2) @(negedge clk);
    check(host_interrupt_pin, 1'b1);
    hstat(16'h0030);
    repeat (2) @(negedge clk);
    check(host_interrupt_pin, 1'b0);
    cpu_op(1'b1, ADDR_DOORBELL1, 16'h0000);
    hread(16'h1000, READ_NONE);
    hstat(16'h0000);
    $display("test doorbell done");
    // mailbox in both directions, with masking
    en_rx = 1'b1;
    en_tx = 1'b1;
    d = 16'($urandom);
    u_host.access(2'd0, ADDR_MAILBOX, d);
    check(irq_rx, 1'b1);
    hstat(16'h0100);
    cq.push_back(d);
    cpu_op(1'b0, ADDR_MAILBOX, 16'h0000);
    @(negedge clk);
    check(irq_rx, 1'b0);
    cpu_op(1'b1, ADDR_MAILBOX, 16'ha5c3);
    repeat (2) @(negedge clk);
    check(host_interrupt_pin, 1'b1);
    check(irq_tx, 1'b0);
    hstat(16'h0001);
    hread(ADDR_MAILBOX, 16'ha5c3);
    @(negedge clk);
    check(irq_tx, 1'b1);
    check(host_interrupt_pin, 1'b0);
    en_tx = 1'b0;
    #1 check(irq_tx, 1'b0);
    @(negedge clk);
    en_tx = 1'b1;
    hstat(16'h0000);
    $display("test mailbox done");
    // swapped lanes on host writes and reads
    set_routing(16'h0101);
    u_host.access(2'd0, ADDR_MAILBOX, 16'h1234);
    cq.push_back(16'h3412);
    cpu_op(1'b0, ADDR_MAILBOX, 16'h0000);
    cpu_op(1'b1, ADDR_MAILBOX, 16'habcd);
    @(negedge clk);
    check(irq_tx, 1'b0);
    hstat(16'h0100);
    hread(ADDR_MAILBOX, 16'hcdab);
    repeat (3) @(negedge clk);
    $display("test swap done");
    end_of_test();
  end
endmodule

/* src/byte_lane_swap.sv */
// optional exchange of the two byte lanes of a 16-bit word
`timescale 1ns/10ps

module byte_lane_swap (
  input wire logic swap,
  input wire logic [15:0] word_in,
  output logic [15:0] word_out
);

  // ==========================================================
  // straight when clear, lanes exchanged when set
  always_comb begin
    if (swap) begin
      word_out = {word_in[7:0], word_in[15:8]};
    end else begin
      word_out = word_in;
    end
  end

endmodule

/* src/host_port_irq_routing_mailbox.sv */
// host port interrupt routing, doorbells, mailbox and status port
`timescale 1ns/10ps

// How it works
// RULE_01 - routed serial engine events drive host interrupt pin and status port
// RULE_02 - routing register written and read by host, only read by cpu
// RULE_03 - routing picks destination only; event enables live elsewhere
// RULE_04 - bit 15 sends vbus event, bit 14 id event to host
// RULE_05 - engine 2 frame event: bit 13 to host, bit 12 to cpu
// RULE_06 - engine 1 frame event: bit 11 to host, bit 10 to cpu
// RULE_07 - software lets only one side clear a doubly routed frame event
// RULE_08 - bit 9 engine 2 bus reset, bit 1 engine 1 to host
// RULE_09 - bit 7 engine 2 resume, bit 6 engine 1 resume to host
// RULE_10 - bit 3 engine 2 done, bit 2 engine 1 done to host
// RULE_11 - swap bits 00 straight lanes, 11 exchanges host data byte lanes
// RULE_12 - software keeps swap bits 8 and 0 equal
// RULE_13 - any cpu doorbell write sets message flag and host interrupt pin
// RULE_14 - message flags clear on a host port read
// RULE_15 - host mailbox write raises rx full; cpu mailbox read clears it
// RULE_16 - host mailbox read raises tx empty; cpu mailbox write clears it
// RULE_17 - cpu mailbox write raises host pin; host mailbox read drops it
// RULE_18 - status port readable by host only, never by cpu
// RULE_19 - status reads make no internal memory cycle
// RULE_20 - status bit 15 vbus comparator, bit 14 id pin level
// RULE_21 - software waits 10 us after vbus on before trusting flag
// RULE_22 - status bit 12 shows engine 2 frame event
// RULE_23 - status bit 8 incoming mailbox, bit 0 outgoing mailbox
// RULE_24 - status bits 5 and 4 show engine 2 and engine 1 messages
module host_port_irq_routing_mailbox
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic host_mem_wr,
  input wire logic host_mem_rd,
  input wire logic host_status_rd,
  input wire logic [15:0] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic host_mem_cycle,
  output logic host_interrupt_pin,
  input wire logic vbus_above_threshold,
  input wire logic otg_id_pin,
  input wire logic vbus_event,
  input wire logic id_event,
  input wire logic engine1_frame_event,
  input wire logic engine2_frame_event,
  input wire logic engine1_bus_reset_event,
  input wire logic engine2_bus_reset_event,
  input wire logic engine1_resume_event,
  input wire logic engine2_resume_event,
  input wire logic engine1_done_event,
  input wire logic engine2_done_event,
  output logic cpu_vbus_irq,
  output logic cpu_id_irq,
  output logic cpu_frame1_irq,
  output logic cpu_frame2_irq,
  output logic cpu_bus_reset_1_irq,
  output logic cpu_bus_reset_2_irq,
  output logic cpu_resume_1_irq,
  output logic cpu_resume_2_irq,
  output logic cpu_done_1_irq,
  output logic cpu_done_2_irq,
  input wire logic mbx_rx_full_irq_en,
  input wire logic mbx_tx_empty_irq_en,
  output logic cpu_mbx_rx_full_irq,
  output logic cpu_mbx_tx_empty_irq
);

  // ==========================================================
  // address match, shared by the cpu and host decoders
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
    return addr == reg_addr;
  endfunction

  logic [15:0] routing;
  logic [15:0] mailbox;
  logic msg1;
  logic msg2;
  logic mbx_in;
  logic mbx_out;
  logic tx_empty;
  logic vbus_level;
  logic id_level;
  logic swap;
  logic [15:0] host_wdata;
  logic [15:0] status_word;
  logic [15:0] next_host_rdata;
  logic [15:0] host_rdata_lanes;
  logic [9:0] host_routed;
  logic host_rd_any;
  logic host_wr_routing;
  logic host_wr_mbx;
  logic host_rd_mbx;
  logic cpu_wr_db1;
  logic cpu_wr_db2;
  logic cpu_wr_mbx;
  logic cpu_rd_mbx;

  // ==========================================================
  // pin levels cross into the clock domain
  pin_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({vbus_above_threshold, otg_id_pin}),
    .level_out({vbus_level, id_level})
  );

  // ==========================================================
  // byte lanes; both swap bits must be set, a mixed pair stays straight
  assign swap = routing[RT_SWAP_HI] & routing[RT_SWAP_LO]; // [RULE_11] [RULE_12]

  byte_lane_swap u_swap_in (
    .swap(swap),
    .word_in(host_data_in),
    .word_out(host_wdata)
  );

  byte_lane_swap u_swap_out (
    .swap(swap),
    .word_in(next_host_rdata),
    .word_out(host_rdata_lanes)
  );

  // ==========================================================
  // access decode
  assign host_rd_any = host_mem_rd | host_status_rd;
  assign host_wr_routing = host_mem_wr & hit(host_addr, ADDR_ROUTING);
  assign host_wr_mbx = host_mem_wr & hit(host_addr, ADDR_MAILBOX);
  assign host_rd_mbx = host_mem_rd & hit(host_addr, ADDR_MAILBOX);
  assign cpu_wr_db1 = cpu_wr & hit(cpu_addr, ADDR_DOORBELL1);
  assign cpu_wr_db2 = cpu_wr & hit(cpu_addr, ADDR_DOORBELL2);
  assign cpu_wr_mbx = cpu_wr & hit(cpu_addr, ADDR_MAILBOX);
  assign cpu_rd_mbx = cpu_rd & hit(cpu_addr, ADDR_MAILBOX);

  // ==========================================================
  // routing register: host writes, cpu writes are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      routing <= ROUTING_RESET;
    end else if (host_wr_routing) begin
      routing <= host_wdata & ROUTING_WRITABLE; // [RULE_02]
    end
  end

  // ==========================================================
  // events to the host; each is gated only by its routing bit
  assign host_routed = {
    vbus_event & routing[RT_VBUS], // [RULE_04]
    id_event & routing[RT_ID], // [RULE_04]
    engine2_frame_event & routing[RT_FRAME2_HOST], // [RULE_05]
    engine1_frame_event & routing[RT_FRAME1_HOST], // [RULE_06]
    engine2_bus_reset_event & routing[RT_RESET_2], // [RULE_08]
    engine2_resume_event & routing[RT_RESUME_2], // [RULE_09]
    engine1_resume_event & routing[RT_RESUME_1], // [RULE_09]
    engine2_done_event & routing[RT_DONE_2], // [RULE_10]
    engine1_done_event & routing[RT_DONE_1], // [RULE_10]
    engine1_bus_reset_event & routing[RT_RESET_1] // [RULE_08]
  };

  // ==========================================================
  // events left with the cpu; frame events have their own cpu bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_vbus_irq <= 1'b0;
      cpu_id_irq <= 1'b0;
      cpu_frame1_irq <= 1'b0;
      cpu_frame2_irq <= 1'b0;
      cpu_bus_reset_1_irq <= 1'b0;
      cpu_bus_reset_2_irq <= 1'b0;
      cpu_resume_1_irq <= 1'b0;
      cpu_resume_2_irq <= 1'b0;
      cpu_done_1_irq <= 1'b0;
      cpu_done_2_irq <= 1'b0;
    end else begin
      cpu_vbus_irq <= vbus_event & ~routing[RT_VBUS]; // [RULE_04] [RULE_03]
      cpu_id_irq <= id_event & ~routing[RT_ID]; // [RULE_04]
      cpu_frame1_irq <= engine1_frame_event & routing[RT_FRAME1_CPU]; // [RULE_06]
      cpu_frame2_irq <= engine2_frame_event & routing[RT_FRAME2_CPU]; // [RULE_05]
      cpu_bus_reset_1_irq <= engine1_bus_reset_event & ~routing[RT_RESET_1]; // [RULE_08]
      cpu_bus_reset_2_irq <= engine2_bus_reset_event & ~routing[RT_RESET_2]; // [RULE_08]
      cpu_resume_1_irq <= engine1_resume_event & ~routing[RT_RESUME_1]; // [RULE_09]
      cpu_resume_2_irq <= engine2_resume_event & ~routing[RT_RESUME_2]; // [RULE_09]
      cpu_done_1_irq <= engine1_done_event & ~routing[RT_DONE_1]; // [RULE_10]
      cpu_done_2_irq <= engine2_done_event & ~routing[RT_DONE_2]; // [RULE_10]
    end
  end

  // ==========================================================
  // doorbell flags; a write in the clearing cycle still sets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg1 <= 1'b0;
      msg2 <= 1'b0;
    end else begin
      if (cpu_wr_db1) begin
        msg1 <= 1'b1; // [RULE_13]
      end else if (host_rd_any) begin
        msg1 <= 1'b0; // [RULE_14]
      end
      if (cpu_wr_db2) begin
        msg2 <= 1'b1; // [RULE_13]
      end else if (host_rd_any) begin
        msg2 <= 1'b0; // [RULE_14]
      end
    end
  end

  // ==========================================================
  // mailbox word; a host write wins a same-cycle collision
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mailbox <= MAILBOX_RESET;
    end else if (host_wr_mbx) begin
      mailbox <= host_wdata;
    end else if (cpu_wr_mbx) begin
      mailbox <= cpu_wdata;
    end
  end

  // ==========================================================
  // mailbox flags, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mbx_in <= 1'b0;
      mbx_out <= 1'b0;
      tx_empty <= 1'b0;
    end else begin
      if (host_wr_mbx) begin
        mbx_in <= 1'b1; // [RULE_15] [RULE_23]
      end else if (cpu_rd_mbx) begin
        mbx_in <= 1'b0; // [RULE_15] [RULE_23]
      end
      if (cpu_wr_mbx) begin
        mbx_out <= 1'b1; // [RULE_17] [RULE_23]
      end else if (host_rd_mbx) begin
        mbx_out <= 1'b0; // [RULE_17] [RULE_23]
      end
      if (host_rd_mbx) begin
        tx_empty <= 1'b1; // [RULE_16]
      end else if (cpu_wr_mbx) begin
        tx_empty <= 1'b0; // [RULE_16]
      end
    end
  end

  // mailbox interrupts to the cpu follow their enables at once
  assign cpu_mbx_rx_full_irq = mbx_in & mbx_rx_full_irq_en; // [RULE_15]
  assign cpu_mbx_tx_empty_irq = tx_empty & mbx_tx_empty_irq_en; // [RULE_16]

  // ==========================================================
  // host status word, reserved bits 13 and 11 read zero
  always_comb begin
    status_word = READ_NONE;
    status_word[ST_VBUS] = vbus_level; // [RULE_20]
    status_word[ST_ID] = id_level; // [RULE_20]
    status_word[ST_FRAME2] = host_routed[7]; // [RULE_22] [RULE_01]
    status_word[ST_FRAME1] = host_routed[6]; // [RULE_01]
    status_word[ST_RESET_2] = host_routed[5]; // [RULE_01]
    status_word[ST_MBX_IN] = mbx_in; // [RULE_23]
    status_word[ST_RESUME_2] = host_routed[4]; // [RULE_01]
    status_word[ST_RESUME_1] = host_routed[3]; // [RULE_01]
    status_word[ST_MSG2] = msg2; // [RULE_24]
    status_word[ST_MSG1] = msg1; // [RULE_24]
    status_word[ST_DONE_2] = host_routed[2]; // [RULE_01]
    status_word[ST_DONE_1] = host_routed[1]; // [RULE_01]
    status_word[ST_RESET_1] = host_routed[0]; // [RULE_01]
    status_word[ST_MBX_OUT] = mbx_out; // [RULE_23]
  end

  // ==========================================================
  // host read mux; unmapped host addresses read zero here
  always_comb begin
    if (host_status_rd) begin
      next_host_rdata = status_word; // [RULE_18]
    end else if (host_mem_rd && hit(host_addr, ADDR_ROUTING)) begin
      next_host_rdata = routing; // [RULE_02]
    end else if (host_rd_mbx) begin
      next_host_rdata = mailbox;
    end else begin
      next_host_rdata = READ_NONE;
    end
  end

  // ==========================================================
  // host data bus: one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_out <= READ_NONE;
      host_data_oe <= 1'b0;
    end else begin
      host_data_out <= host_rdata_lanes; // [RULE_11]
      host_data_oe <= host_rd_any;
    end
  end

  // status reads stay off the internal memory path so polling is free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_mem_cycle <= 1'b0;
    end else begin
      host_mem_cycle <= host_mem_rd | host_mem_wr; // [RULE_19]
    end
  end

  // ==========================================================
  // host interrupt pin from every host-bound source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_interrupt_pin <= 1'b0;
    end else begin
      host_interrupt_pin <= (|host_routed) | msg1 | msg2 | mbx_out; // [RULE_01] [RULE_13] [RULE_17]
    end
  end

  // ==========================================================
  // cpu read port; status port is not visible from this side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= READ_NONE;
    end else if (cpu_rd && hit(cpu_addr, ADDR_ROUTING)) begin
      cpu_rdata <= routing; // [RULE_02]
    end else if (cpu_rd_mbx) begin
      cpu_rdata <= mailbox;
    end else begin
      cpu_rdata <= READ_NONE; // [RULE_18]
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_done_1_to_host;
    engine1_done_event && routing[RT_DONE_1] |=> host_interrupt_pin;
  endproperty
  a_done_1_to_host: assert property (p_done_1_to_host) else $error("routed done lost"); // [RULE_10]

  property p_routing_cpu_ro;
    cpu_wr && hit(cpu_addr, ADDR_ROUTING) && !host_wr_routing |=> $stable(routing);
  endproperty
  a_routing_cpu_ro: assert property (p_routing_cpu_ro) else $error("cpu changed routing"); // [RULE_02]

  property p_vbus_dest;
    vbus_event |=> cpu_vbus_irq != $past(routing[RT_VBUS]);
  endproperty
  a_vbus_dest: assert property (p_vbus_dest) else $error("vbus event misrouted"); // [RULE_04]

  property p_frame2_both;
    engine2_frame_event && routing[RT_FRAME2_HOST] && routing[RT_FRAME2_CPU]
      |=> cpu_frame2_irq && host_interrupt_pin;
  endproperty
  a_frame2_both: assert property (p_frame2_both) else $error("frame2 not at both"); // [RULE_05]

  property p_frame1_cpu_off;
    !routing[RT_FRAME1_CPU] |=> !cpu_frame1_irq;
  endproperty
  a_frame1_cpu_off: assert property (p_frame1_cpu_off) else $error("frame1 leaked to cpu"); // [RULE_06]

  property p_swap_lanes;
    host_status_rd && swap |=>
      host_data_out == {$past(status_word[7:0]), $past(status_word[15:8])} && host_data_oe;
  endproperty
  a_swap_lanes: assert property (p_swap_lanes) else $error("byte lanes not swapped"); // [RULE_11]

  property p_doorbell;
    cpu_wr_db1 |=> msg1 ##1 host_interrupt_pin;
  endproperty
  a_doorbell: assert property (p_doorbell) else $error("doorbell did not signal"); // [RULE_13]

  property p_msg_clear;
    msg2 && host_rd_any && !cpu_wr_db2 |=> !msg2;
  endproperty
  a_msg_clear: assert property (p_msg_clear) else $error("message flag stuck"); // [RULE_14]

  property p_rx_full;
    host_wr_mbx && mbx_rx_full_irq_en |=> cpu_mbx_rx_full_irq;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full missing"); // [RULE_15]

  property p_tx_empty;
    cpu_wr_mbx && !host_rd_mbx |=> !cpu_mbx_tx_empty_irq;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty not cleared"); // [RULE_16]

  property p_mbx_pin_drop;
    host_rd_mbx && !cpu_wr_mbx && !cpu_wr_db1 && !cpu_wr_db2
      |=> !mbx_out ##1 ($past(host_routed) != 10'h000 || !host_interrupt_pin);
  endproperty
  a_mbx_pin_drop: assert property (p_mbx_pin_drop) else $error("host pin stayed up"); // [RULE_17]

  property p_status_no_cycle;
    host_status_rd && !host_mem_rd && !host_mem_wr |=> !host_mem_cycle;
  endproperty
  a_status_no_cycle: assert property (p_status_no_cycle) else $error("status made a cycle"); // [RULE_19]

  property p_frame2_flag;
    host_status_rd && !swap && engine2_frame_event && routing[RT_FRAME2_HOST]
      |=> host_data_out[ST_FRAME2];
  endproperty
  a_frame2_flag: assert property (p_frame2_flag) else $error("frame2 flag missing"); // [RULE_22]

  c_mbx_round: cover property (cpu_wr_mbx ##[1:20] host_rd_mbx);
  c_doorbell_read: cover property (cpu_wr_db2 ##[1:20] host_status_rd);
  c_swapped_read: cover property (swap && host_mem_rd);

endmodule

/* src/host_port_pkg.sv */
// constants shared by the host port routing and mailbox logic
package host_port_pkg;

  // ==========================================================
  // register addresses
  localparam logic [15:0] ADDR_ROUTING = 16'h0142;
  localparam logic [15:0] ADDR_DOORBELL1 = 16'h0144;
  localparam logic [15:0] ADDR_DOORBELL2 = 16'h0148;
  localparam logic [15:0] ADDR_MAILBOX = 16'hc0c6;

  // ==========================================================
  // reset values and masks
  localparam logic [15:0] ROUTING_RESET = 16'h1400;
  localparam logic [15:0] ROUTING_WRITABLE = 16'hffcf;
  localparam logic [15:0] MAILBOX_RESET = 16'h0000;
  localparam logic [15:0] READ_NONE = 16'h0000;

  // ==========================================================
  // routing register bit positions
  localparam int RT_VBUS = 15;
  localparam int RT_ID = 14;
  localparam int RT_FRAME2_HOST = 13;
  localparam int RT_FRAME2_CPU = 12;
  localparam int RT_FRAME1_HOST = 11;
  localparam int RT_FRAME1_CPU = 10;
  localparam int RT_RESET_2 = 9;
  localparam int RT_SWAP_HI = 8;
  localparam int RT_RESUME_2 = 7;
  localparam int RT_RESUME_1 = 6;
  localparam int RT_DONE_2 = 3;
  localparam int RT_DONE_1 = 2;
  localparam int RT_RESET_1 = 1;
  localparam int RT_SWAP_LO = 0;

  // ==========================================================
  // host status port bit positions
  localparam int ST_VBUS = 15;
  localparam int ST_ID = 14;
  localparam int ST_FRAME2 = 12;
  localparam int ST_FRAME1 = 10;
  localparam int ST_RESET_2 = 9;
  localparam int ST_MBX_IN = 8;
  localparam int ST_RESUME_2 = 7;
  localparam int ST_RESUME_1 = 6;
  localparam int ST_MSG2 = 5;
  localparam int ST_MSG1 = 4;
  localparam int ST_DONE_2 = 3;
  localparam int ST_DONE_1 = 2;
  localparam int ST_RESET_1 = 1;
  localparam int ST_MBX_OUT = 0;

endpackage

/* src/pin_sync2.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/10ps

module pin_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // ==========================================================
  // one chain per bit; first stage is read only by the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1 <= 1'b0;
          level_out[i] <= 1'b0;
        end else begin
          stage1 <= pin_in[i];
          level_out[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule
